// ### rtl/pspr_top.sv
/*
 * Port sideband and prefetch register bank of a quad port expander: output
 * enables for module sideband and indicator pins, values for the sideband pins only, prefetch gates,
 * event prefetch source selection, second-address masking, done-strobe pin
 * function select and a live pin status register.
 * Assumes a host interface slave drives the local register port in the same
 * clock domain, that prefetch engines report completion as one-cycle pulses,
 * and that the pads resolve the output enables.
 */
`timescale 1ns/1ns
`include "pspr_cfg.svh"

// How it works
// RL1 - Sideband output enables per port nibble.
// RL2 - Amber and green indicator output enables.
// RL3 - Output value register drives sideband outputs.
// RL4 - Event gate set forwards event range.
// RL5 - Event prefetch success clears event gate.
// RL6 - Rearm or disable sets event gate.
// RL7 - Overlap reads come from event memory.
// RL8 - Periodic gate forwards; success clears it.
// RL9 - Host sets periodic gate on range change.
// RL10 - Source codes: off, fault, absent, loss.
// RL11 - Two-bit source fields, port three highest.
// RL12 - Absence bit NACKs address A2 locally.
// RL13 - Select field routes indicator clock out.
// RL14 - Status bits show interface, sync, strobes.
// RL15 - Status low nibble shows general pins.
// RL16 - Port reset returns that port's prefetch gates to their reset value and clears its event level history.
// RL17 - Disabled output stays undriven, value ignored.
module pspr_top #(
    parameter int NUM_PORTS = 4
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic [3:0] PORT_RST,
    input wire pspr_pkg::pspr_mod_in_t MOD_IN,
    input wire logic [7:0] PIN_STAT_IN,
    input wire logic [3:0] EVT_PREFETCH_DONE,
    input wire logic [3:0] PER_PREFETCH_DONE,
    input wire pspr_pkg::pspr_acc_t ACC,
    output pspr_pkg::pspr_route_t ACC_ROUTE,
    output logic ACC_ROUTE_VALID,
    output logic [3:0] EVT_PREFETCH_START,
    output pspr_pkg::pspr_sb_out_t SB_OUT,
    input wire logic INDICATOR_CLK,
    input wire logic DONE_FUNC_O,
    input wire logic DONE_FUNC_OE,
    output logic DONE_PIN_O,
    output logic DONE_PIN_OE
);
    import pspr_pkg::*;

    initial begin
        if (NUM_PORTS != 4) begin
            $error("pspr_top: the register layout serves exactly four ports.");
        end
    end

    localparam int SYNC_W = 20;

    // Gate reset value, event gates in the upper nibble and periodic gates in the lower.
    localparam logic [7:0] GATE_RST = `PSPR_RST_GATE;

    // Register state.
    logic [7:0] sb_oe_r, sb_oe_nxt;
    logic [7:0] ind_oe_r, ind_oe_nxt;
    logic [7:0] sb_val_r, sb_val_nxt;
    logic [3:0] evt_gate_r, evt_gate_nxt;
    logic [3:0] per_gate_r, per_gate_nxt;
    logic [7:0] evt_src_r, evt_src_nxt;
    logic [3:0] a2_abs_r, a2_abs_nxt;
    logic [2:0] clk_sel_r, clk_sel_nxt;
    logic [7:0] rdata_r, rdata_nxt;

    // Event trigger state.
    logic [3:0] evt_lvl_prev_r, evt_lvl_prev_nxt;
    logic [3:0] evt_start_r, evt_start_nxt;

    // Output state.
    pspr_route_t route_r, route_nxt;
    logic route_vld_r, route_vld_nxt;
    pspr_sb_out_t sb_out_r, sb_out_nxt;
    logic done_o_r, done_o_nxt;
    logic done_oe_r, done_oe_nxt;

    // Conditioned pin levels.
    logic [SYNC_W-1:0] sync_in;
    logic [SYNC_W-1:0] sync_lvl;
    logic [3:0] tx_fault_lvl, absent_lvl, rx_loss_lvl;
    logic [7:0] pin_stat_lvl;
    logic [3:0] evt_lvl;

    assign sync_in = {PIN_STAT_IN, MOD_IN.tx_fault, MOD_IN.module_absent_input, MOD_IN.receive_loss_input};

    // All pin inputs pass the three-stage conditioner.
    pspr_pin_sync #(
        .WIDTH(SYNC_W)
    ) u_sync (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .pin_in(sync_in),
        .level_out(sync_lvl)
    );

    assign pin_stat_lvl = sync_lvl[19:12];
    assign tx_fault_lvl = sync_lvl[11:8];
    assign absent_lvl = sync_lvl[7:4];
    assign rx_loss_lvl = sync_lvl[3:0];

    // Per port, pick the event source level from the two-bit field.
    genvar p;
    generate
        for (p = 0; p < 4; p++) begin : g_src
            always_comb begin
                case (evt_src_r[2*p +: 2]) // [RL11]
                    `PSPR_SRC_TX_FAULT: evt_lvl[p] = tx_fault_lvl[p]; // [RL10]
                    `PSPR_SRC_ABSENT: evt_lvl[p] = absent_lvl[p]; // [RL10]
                    `PSPR_SRC_RX_LOSS: evt_lvl[p] = rx_loss_lvl[p]; // [RL10]
                    default: evt_lvl[p] = 1'b0; // [RL10]
                endcase
            end
        end
    endgenerate

    // Register writes, gate updates and event triggering.
    always_comb begin
        logic wr_src;
        logic [3:0] src_changed;
        logic [3:0] rearm;
        wr_src = REG_WR && (REG_ADDR == `PSPR_OFS_EVT_SRC);
        src_changed = '0;
        rearm = '0;
        sb_oe_nxt = sb_oe_r;
        ind_oe_nxt = ind_oe_r;
        sb_val_nxt = sb_val_r;
        evt_src_nxt = evt_src_r;
        a2_abs_nxt = a2_abs_r;
        clk_sel_nxt = clk_sel_r;
        per_gate_nxt = per_gate_r & ~PER_PREFETCH_DONE; // [RL8]
        if (REG_WR) begin
            case (REG_ADDR)
                `PSPR_OFS_SB_OE: sb_oe_nxt = REG_WDATA; // [RL1]
                `PSPR_OFS_IND_OE: ind_oe_nxt = REG_WDATA; // [RL2]
                `PSPR_OFS_SB_VAL: sb_val_nxt = REG_WDATA; // [RL3]
                `PSPR_OFS_GATE: per_gate_nxt = REG_WDATA[`PSPR_LO_MSB:`PSPR_LO_LSB]; // [RL9]
                `PSPR_OFS_EVT_SRC: evt_src_nxt = REG_WDATA;
                `PSPR_OFS_A2_ABS: a2_abs_nxt = REG_WDATA[`PSPR_LO_MSB:`PSPR_LO_LSB];
                `PSPR_OFS_CLK_SEL: clk_sel_nxt = REG_WDATA[`PSPR_CLK_SEL_MSB:`PSPR_CLK_SEL_LSB];
                default: begin
                end
            endcase
        end
        for (int i = 0; i < 4; i++) begin
            if (wr_src && (REG_WDATA[2*i +: 2] != evt_src_r[2*i +: 2])) begin
                src_changed[i] = 1'b1;
            end
        end
        // A rising source level re-arms the event prefetch of that port.
        evt_lvl_prev_nxt = evt_lvl;
        evt_start_nxt = evt_lvl & ~evt_lvl_prev_r & ~PORT_RST;
        rearm = evt_start_nxt | src_changed;
        // Setting wins over a completion in the same cycle.
        evt_gate_nxt = (evt_gate_r & ~EVT_PREFETCH_DONE) | rearm; // [RL5] [RL6]
        // A port held in reset returns to its reset prefetch state.
        for (int i = 0; i < 4; i++) begin
            if (PORT_RST[i]) begin
                evt_gate_nxt[i] = GATE_RST[i + 4]; // [RL16]
                per_gate_nxt[i] = GATE_RST[i]; // [RL16]
                evt_lvl_prev_nxt[i] = 1'b0; // [RL16]
            end
        end
    end

    // Read data, captured on a read strobe.
    always_comb begin
        rdata_nxt = rdata_r;
        if (REG_RD) begin
            case (REG_ADDR)
                `PSPR_OFS_SB_OE: rdata_nxt = sb_oe_r;
                `PSPR_OFS_IND_OE: rdata_nxt = ind_oe_r;
                `PSPR_OFS_SB_VAL: rdata_nxt = sb_val_r;
                `PSPR_OFS_GATE: rdata_nxt = {evt_gate_r, per_gate_r};
                `PSPR_OFS_EVT_SRC: rdata_nxt = evt_src_r;
                `PSPR_OFS_A2_ABS: rdata_nxt = {4'h0, a2_abs_r};
                `PSPR_OFS_CLK_SEL: rdata_nxt = {clk_sel_r, 5'h00};
                `PSPR_OFS_PIN_STAT: rdata_nxt = pin_stat_lvl; // [RL14] [RL15]
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // Route a host access: masked address, then event range, then periodic.
    always_comb begin
        logic [1:0] pt;
        pt = ACC.port;
        route_vld_nxt = ACC.valid;
        route_nxt = ROUTE_NONE;
        if (ACC.valid) begin
            if (a2_abs_r[pt] && (ACC.dev_addr == `PSPR_DEV_ADDR_A2)) begin
                route_nxt = ROUTE_NACK; // [RL12]
            end else if (ACC.in_evt_range && (evt_src_r[2*pt +: 2] != `PSPR_SRC_OFF)) begin
                route_nxt = evt_gate_r[pt] ? ROUTE_FWD : ROUTE_EVT_MEM; // [RL4] [RL7]
            end else if (ACC.in_per_range) begin
                route_nxt = per_gate_r[pt] ? ROUTE_FWD : ROUTE_PER_MEM; // [RL8]
            end else begin
                route_nxt = ROUTE_FWD;
            end
        end
    end

    // Pin outputs; a disabled output drives low with its enable off.
    always_comb begin
        sb_out_nxt.rate_select_or_low_power_oe = sb_oe_r[`PSPR_HI_MSB:`PSPR_HI_LSB]; // [RL1]
        sb_out_nxt.tx_disable_oe = sb_oe_r[`PSPR_LO_MSB:`PSPR_LO_LSB]; // [RL1]
        sb_out_nxt.amber_indicator_oe = ind_oe_r[`PSPR_HI_MSB:`PSPR_HI_LSB]; // [RL2]
        sb_out_nxt.green_indicator_oe = ind_oe_r[`PSPR_LO_MSB:`PSPR_LO_LSB]; // [RL2]
        sb_out_nxt.rate_select_or_low_power = sb_val_r[`PSPR_HI_MSB:`PSPR_HI_LSB]
            & sb_oe_r[`PSPR_HI_MSB:`PSPR_HI_LSB]; // [RL3] [RL17]
        sb_out_nxt.tx_disable = sb_val_r[`PSPR_LO_MSB:`PSPR_LO_LSB]
            & sb_oe_r[`PSPR_LO_MSB:`PSPR_LO_LSB]; // [RL3] [RL17]
        if (clk_sel_r == `PSPR_CLK_SEL_IND_CLK) begin
            done_o_nxt = INDICATOR_CLK; // [RL13]
            done_oe_nxt = 1'b1; // [RL13]
        end else begin
            done_o_nxt = DONE_FUNC_O & DONE_FUNC_OE; // [RL13]
            done_oe_nxt = DONE_FUNC_OE; // [RL13]
        end
    end

    // Register bank, gate and event trigger state.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sb_oe_r <= `PSPR_RST_SB_OE;
            ind_oe_r <= `PSPR_RST_IND_OE;
            sb_val_r <= `PSPR_RST_SB_VAL;
            evt_gate_r <= GATE_RST[`PSPR_HI_MSB:`PSPR_HI_LSB];
            per_gate_r <= GATE_RST[`PSPR_LO_MSB:`PSPR_LO_LSB];
            evt_src_r <= `PSPR_RST_EVT_SRC;
            a2_abs_r <= `PSPR_RST_A2_ABS;
            clk_sel_r <= `PSPR_RST_CLK_SEL;
            evt_lvl_prev_r <= 4'h0;
            evt_start_r <= 4'h0;
        end else begin
            sb_oe_r <= sb_oe_nxt;
            ind_oe_r <= ind_oe_nxt;
            sb_val_r <= sb_val_nxt;
            evt_gate_r <= evt_gate_nxt;
            per_gate_r <= per_gate_nxt;
            evt_src_r <= evt_src_nxt;
            a2_abs_r <= a2_abs_nxt;
            clk_sel_r <= clk_sel_nxt;
            evt_lvl_prev_r <= evt_lvl_prev_nxt;
            evt_start_r <= evt_start_nxt;
        end
    end

    // Read data register; it holds between read strobes.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // Routing answer, one cycle after the access.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            route_r <= ROUTE_NONE;
            route_vld_r <= 1'b0;
        end else begin
            route_r <= route_nxt;
            route_vld_r <= route_vld_nxt;
        end
    end

    // Pin drive registers, so the pads see no combinational glitches.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sb_out_r <= '0;
            done_o_r <= 1'b0;
            done_oe_r <= 1'b0;
        end else begin
            sb_out_r <= sb_out_nxt;
            done_o_r <= done_o_nxt;
            done_oe_r <= done_oe_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
    assign ACC_ROUTE = route_r;
    assign ACC_ROUTE_VALID = route_vld_r;
    assign EVT_PREFETCH_START = evt_start_r;
    assign SB_OUT = sb_out_r;
    assign DONE_PIN_O = done_o_r;
    assign DONE_PIN_OE = done_oe_r;

endmodule

// ### rtl/pspr_cfg.svh
/*
 * Offsets, field positions and reset values of the port sideband and
 * prefetch register bank.
 * Assumes it is included by its bare name from files that need the numbers.
 */
`ifndef PSPR_CFG_SVH
`define PSPR_CFG_SVH

// Register offsets on the local register port.
`define PSPR_OFS_SB_OE 8'h08
`define PSPR_OFS_IND_OE 8'h09
`define PSPR_OFS_SB_VAL 8'h0a
`define PSPR_OFS_GATE 8'h0b
`define PSPR_OFS_EVT_SRC 8'h0c
`define PSPR_OFS_A2_ABS 8'h0d
`define PSPR_OFS_CLK_SEL 8'h0e
`define PSPR_OFS_PIN_STAT 8'h0f

// Reset values.
`define PSPR_RST_SB_OE 8'h00
`define PSPR_RST_IND_OE 8'hff
`define PSPR_RST_SB_VAL 8'h0f
`define PSPR_RST_GATE 8'hff
`define PSPR_RST_EVT_SRC 8'h00
`define PSPR_RST_A2_ABS 4'h0
`define PSPR_RST_CLK_SEL 3'h0

// Field positions: upper nibble and lower nibble of the per-port registers.
`define PSPR_HI_MSB 7
`define PSPR_HI_LSB 4
`define PSPR_LO_MSB 3
`define PSPR_LO_LSB 0

// Done-strobe pin function select field and its codes.
`define PSPR_CLK_SEL_MSB 7
`define PSPR_CLK_SEL_LSB 5
`define PSPR_CLK_SEL_DEFAULT 3'h0
`define PSPR_CLK_SEL_IND_CLK 3'h1

// Event prefetch source codes.
`define PSPR_SRC_OFF 2'h0
`define PSPR_SRC_TX_FAULT 2'h1
`define PSPR_SRC_ABSENT 2'h2
`define PSPR_SRC_RX_LOSS 2'h3

// Downstream device address that the absence bits hide.
`define PSPR_DEV_ADDR_A2 8'ha2

`endif

// ### rtl/pspr_pkg.sv
/*
 * Types shared by the port sideband and prefetch register bank.
 * Assumes four downstream ports.
 */
package pspr_pkg;

    // Where a host access to a downstream port is to be served.
    typedef enum logic [2:0] {
        ROUTE_NONE,
        ROUTE_EVT_MEM,
        ROUTE_PER_MEM,
        ROUTE_FWD,
        ROUTE_NACK
    } pspr_route_t;

    // One host access presented for routing.
    typedef struct packed {
        logic valid;
        logic [1:0] port;
        logic in_evt_range;
        logic in_per_range;
        logic [7:0] dev_addr;
    } pspr_acc_t;

    // Module status inputs of the four ports, raw from the pins.
    typedef struct packed {
        logic [3:0] tx_fault;
        logic [3:0] module_absent_input;
        logic [3:0] receive_loss_input;
    } pspr_mod_in_t;

    // Per-port sideband outputs with their enables.
    typedef struct packed {
        logic [3:0] rate_select_or_low_power;
        logic [3:0] rate_select_or_low_power_oe;
        logic [3:0] tx_disable;
        logic [3:0] tx_disable_oe;
        logic [3:0] amber_indicator_oe;
        logic [3:0] green_indicator_oe;
    } pspr_sb_out_t;

endpackage

// ### rtl/pspr_pin_sync.sv
/*
 * Pin input conditioner: three stage flip-flops and a level flip-flop per bit, and the output level only
 * changes once the second and third stage agree.
 * Assumes the inputs are asynchronous to clk.
 */
`timescale 1ns/1ns
module pspr_pin_sync #(
    parameter int WIDTH = 20
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);

    initial begin
        if (WIDTH < 1) begin
            $error("pspr_pin_sync: WIDTH must be at least 1.");
        end
    end

    logic [WIDTH-1:0] s1_r, s2_r, s3_r, lvl_r;
    logic [WIDTH-1:0] lvl_nxt;

    // Per bit, accept the new level only when stages two and three agree.
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
            end
        end
    endgenerate

    // Stage registers; the first stage feeds only the second.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            lvl_r <= '0;
        end else begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            lvl_r <= lvl_nxt;
        end
    end

    assign level_out = lvl_r;

endmodule

// ### tb/pspr_top_asserts.sv
/*
 * Checker for the port sideband and prefetch register bank.
 * Assumes it is bound to pspr_top and sees only that module's ports.
 */
`timescale 1ns/1ns
module pspr_top_asserts (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic [3:0] PORT_RST,
    input wire pspr_pkg::pspr_acc_t ACC,
    input wire pspr_pkg::pspr_route_t ACC_ROUTE,
    input wire logic ACC_ROUTE_VALID,
    input wire logic [3:0] EVT_PREFETCH_START,
    input wire pspr_pkg::pspr_sb_out_t SB_OUT,
    input wire logic INDICATOR_CLK,
    input wire logic DONE_FUNC_O,
    input wire logic DONE_FUNC_OE,
    input wire logic DONE_PIN_O,
    input wire logic DONE_PIN_OE
);
    import pspr_pkg::*;
    logic [7:0] oe_r, ind_r, val_r, src_r, rd_exp;
    logic [3:0] abs_r;
    logic [2:0] sel_r;
    logic [1:0] age_r;
    logic [23:0] sb_exp;
    // Shadow copies of the writable registers except the gate register, plus a settle count after reset.
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            {oe_r, ind_r, val_r, src_r} <= 32'h00ff0f00;
            abs_r <= 4'h0;
            sel_r <= 3'h0;
            age_r <= 2'h0;
        end else begin
            if (age_r != 2'h3) age_r <= age_r + 2'h1;
            if (REG_WR) begin
                case (REG_ADDR)
                    8'h08: oe_r <= REG_WDATA;
                    8'h09: ind_r <= REG_WDATA;
                    8'h0a: val_r <= REG_WDATA;
                    8'h0c: src_r <= REG_WDATA;
                    8'h0d: abs_r <= REG_WDATA[3:0];
                    8'h0e: sel_r <= REG_WDATA[7:5];
                    default: ;
                endcase
            end
        end
    end
    // Expected read data and expected pin drive, both from the shadows.
    always_comb begin
        case (REG_ADDR)
            8'h08: rd_exp = oe_r;
            8'h09: rd_exp = ind_r;
            8'h0a: rd_exp = val_r;
            8'h0c: rd_exp = src_r;
            8'h0d: rd_exp = {4'h0, abs_r};
            8'h0e: rd_exp = {sel_r, 5'h00};
            default: rd_exp = 8'h00;
        endcase
    end
    assign sb_exp = {val_r[7:4] & oe_r[7:4], oe_r[7:4], val_r[3:0] & oe_r[3:0], oe_r[3:0], ind_r};
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    sideband_drive_a:
        assert property (age_r == 2'h3 |-> SB_OUT[23:8] == $past(sb_exp[23:8])) else $error("sideband drive wrong");
    indicator_enable_a:
        assert property (age_r == 2'h3 |-> SB_OUT[7:0] == $past(sb_exp[7:0])) else $error("indicator enable wrong");
    read_data_a:
        assert property (REG_RD && REG_ADDR != 8'h0b && REG_ADDR != 8'h0f |=> REG_RDATA == $past(rd_exp))
            else $error("read data wrong");
    second_addr_nack_a:
        assert property (ACC.valid && abs_r[ACC.port] && ACC.dev_addr == 8'ha2 |=> ACC_ROUTE == ROUTE_NACK)
            else $error("hidden address not refused");
    route_pulse_a:
        assert property (age_r == 2'h3 |-> ACC_ROUTE_VALID == $past(ACC.valid)) else $error("route pulse wrong");
    route_idle_a:
        assert property (!ACC_ROUTE_VALID |-> ACC_ROUTE == ROUTE_NONE) else $error("route not idle");
    start_single_a:
        assert property (|EVT_PREFETCH_START |=> (EVT_PREFETCH_START & $past(EVT_PREFETCH_START)) == 4'h0)
            else $error("start pulse too long");
    reset_blocks_a:
        assert property ((EVT_PREFETCH_START & PORT_RST & $past(PORT_RST)) == 4'h0) else $error("start in reset");
    done_pin_a:
        assert property (age_r == 2'h3 |-> DONE_PIN_O == $past(sel_r == 3'h1 ? INDICATOR_CLK : DONE_FUNC_O && DONE_FUNC_OE)
            && DONE_PIN_OE == $past(sel_r == 3'h1 || DONE_FUNC_OE)) else $error("done pin drive wrong");
    cover property (ACC_ROUTE_VALID && ACC_ROUTE == ROUTE_NACK);
    cover property (|EVT_PREFETCH_START);
    cover property (sel_r == 3'h1 && DONE_PIN_OE);
endmodule

bind pspr_top pspr_top_asserts u_chk (.REF_CLK, .ARST_N, .REG_ADDR, .REG_WR, .REG_WDATA, .REG_RD, .REG_RDATA,
    .PORT_RST, .ACC, .ACC_ROUTE, .ACC_ROUTE_VALID, .EVT_PREFETCH_START, .SB_OUT, .INDICATOR_CLK,
    .DONE_FUNC_O, .DONE_FUNC_OE, .DONE_PIN_O, .DONE_PIN_OE);

// ### tb/pspr_engine_model.sv
/*
 * Prefetch engine model standing behind the event prefetch handshake.
 * Assumes one-cycle start pulses; answers each with one done pulse, fast or slow.
 */
`timescale 1ns/1ns
module pspr_engine_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [3:0] start,
    input wire logic slow,
    output logic [3:0] done
);
    logic [4:0] cnt_r [4];
    // Per-port countdown; the done pulse marks a successful fetch.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            done <= 4'h0;
            for (int i = 0; i < 4; i++) cnt_r[i] <= 5'h00;
        end else begin
            for (int i = 0; i < 4; i++) begin
                done[i] <= cnt_r[i] == 5'h01;
                if (start[i]) cnt_r[i] <= slow ? 5'h14 : 5'h02;
                else if (cnt_r[i] != 5'h00) cnt_r[i] <= cnt_r[i] - 5'h01;
            end
        end
    end
endmodule

// ### tb/testbench.sv
/*
 * Self-checking testbench for the port sideband and prefetch register bank.
 * Assumes the checker is bound in and the engine model answers start pulses.
 */
`timescale 1ns/1ns
module testbench;
    import pspr_pkg::*;
    logic clk, arst_n, reg_wr, reg_rd, done_fo, done_foe, slow, route_v, done_o, done_oe;
    logic ind_clk = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, pst;
    logic [3:0] prst, evt_done, per_done, evt_start;
    logic [7:0] rst_tab [8] = '{8'h00, 8'hff, 8'h0f, 8'hff, 8'h00, 8'h00, 8'h00, 8'h96};
    pspr_mod_in_t mod;
    pspr_acc_t acc_in;
    pspr_route_t route;
    pspr_sb_out_t sb;
    int n_fail, n_compared;
    pspr_top DUT (.REF_CLK(clk), .ARST_N(arst_n), .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_WDATA(reg_wdata),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .PORT_RST(prst), .MOD_IN(mod), .PIN_STAT_IN(pst),
        .EVT_PREFETCH_DONE(evt_done), .PER_PREFETCH_DONE(per_done), .ACC(acc_in), .ACC_ROUTE(route),
        .ACC_ROUTE_VALID(route_v), .EVT_PREFETCH_START(evt_start), .SB_OUT(sb), .INDICATOR_CLK(ind_clk),
        .DONE_FUNC_O(done_fo), .DONE_FUNC_OE(done_foe), .DONE_PIN_O(done_o), .DONE_PIN_OE(done_oe));
    pspr_engine_model u_eng (.clk(clk), .arst_n(arst_n), .start(evt_start), .slow(slow), .done(evt_done));
    // Main clock at 50 MHz.
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Indicator clock toggles every cycle so the done pin has something to follow.
    always @(posedge clk) ind_clk <= ~ind_clk;
    task final_report;
        $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task chk(input logic [23:0] g, input logic [23:0] e);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #2;
        reg_wr = 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        #2;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk);
        #2;
        reg_rd = 1'b0;
        @(posedge clk);
        #2;
        chk(reg_rdata, e);
    endtask
    task acc(input logic [1:0] p, input logic ev, input logic pe, input logic [7:0] a, input pspr_route_t r);
        @(posedge clk);
        #2;
        acc_in = {1'b1, p, ev, pe, a};
        @(posedge clk);
        #2;
        acc_in.valid = 1'b0;
        chk({route_v, route}, {1'b1, r});
    endtask
    // Raise a module input, watch a bounded window for the start pulse, then let it fall.
    task trig(input int p, input logic [11:0] m, input logic want);
        logic seen;
        seen = 1'b0;
        mod = m;
        repeat (12) begin
            @(posedge clk);
            #2;
            if (evt_start[p]) seen = 1'b1;
        end
        chk(seen, want);
        if (seen !== want) final_report;
        mod = 12'h000;
        repeat (6) @(posedge clk);
    endtask
    // Stops a hung run.
    initial begin
        #400000;
        n_fail++;
        final_report;
    end
    // Main sequence of scenarios.
    initial begin
        {arst_n, reg_wr, reg_rd, done_fo, done_foe, slow} = 6'h06;
        {reg_addr, reg_wdata, prst, per_done} = 24'h000000;
        pst = 8'h96;
        mod = 12'h000;
        acc_in = '0;
        n_fail = 0;
        n_compared = 0;
        repeat (6) @(posedge clk);
        #2;
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++) rd(8'h08 + 8'(i), rst_tab[i]);
        rd(8'h10, 8'h00);
        wr(8'h08, 8'ha5);
        wr(8'h09, 8'h3c);
        wr(8'h0a, 8'h6c);
        wr(8'h0f, 8'h00);
        rd(8'h0f, 8'h96);
        chk(sb, 24'h2a453c);
        wr(8'h0d, 8'hff);
        rd(8'h0d, 8'h0f);
        wr(8'h0b, 8'h00);
        rd(8'h0b, 8'hf0);
        acc(2'h3, 1'b0, 1'b1, 8'h50, ROUTE_PER_MEM);
        wr(8'h0b, 8'h0f);
        chk(done_oe, 1'b1);
        wr(8'h0e, 8'h20);
        done_foe = 1'b0;
        rd(8'h0e, 8'h20);
        chk(done_oe, 1'b1);
        wr(8'h0e, 8'hff);
        rd(8'h0e, 8'he0);
        chk(done_oe, 1'b0);
        wr(8'h0d, 8'h02);
        acc(2'h1, 1'b0, 1'b0, 8'ha2, ROUTE_NACK);
        acc(2'h0, 1'b0, 1'b0, 8'ha2, ROUTE_FWD);
        acc(2'h1, 1'b0, 1'b1, 8'ha0, ROUTE_FWD);
        @(posedge clk);
        #2;
        per_done = 4'h4;
        @(posedge clk);
        #2;
        per_done = 4'h0;
        rd(8'h0b, 8'hfb);
        acc(2'h2, 1'b0, 1'b1, 8'h50, ROUTE_PER_MEM);
        wr(8'h0c, 8'h04);
        trig(1, 12'h200, 1'b1);
        rd(8'h0b, 8'hdb);
        acc(2'h1, 1'b1, 1'b1, 8'h00, ROUTE_EVT_MEM);
        wr(8'h0c, 8'h0c);
        rd(8'h0b, 8'hfb);
        acc(2'h1, 1'b1, 1'b0, 8'h00, ROUTE_FWD);
        trig(1, 12'h002, 1'b1);
        for (int c = 1; c < 4; c++) begin
            wr(8'h0c, 8'(c));
            trig(0, 12'h001 << (4 * (3 - c)), 1'b1);
        end
        wr(8'h0c, 8'h00);
        trig(0, 12'h111, 1'b0);
        slow = 1'b1;
        wr(8'h0c, 8'h01);
        trig(0, 12'h100, 1'b1);
        rd(8'h0b, 8'hfb);
        repeat (20) @(posedge clk);
        rd(8'h0b, 8'heb);
        wr(8'h0b, 8'h00);
        prst = 4'h1;
        trig(0, 12'h100, 1'b0);
        rd(8'h0b, 8'hf1);
        prst = 4'h0;
        final_report;
    end
endmodule
